// >>> hdl/sbd_map.vh
`ifndef SBD_MAP_VH
`define SBD_MAP_VH
// register word indices; the byte address on the bus is index * 4
`define SBD_IDX_STATUS 7'h50
`define SBD_IDX_DATA 7'h51
`define SBD_IDX_BAUD 7'h52
`define SBD_IDX_CTRL1 7'h53
`define SBD_IDX_CTRL2 7'h54
`define SBD_IDX_EXT_RX 7'h55
`define SBD_IDX_HOLE 7'h56
`define SBD_IDX_EXT_TX 7'h57
`define SBD_IDX_IRQ_STAT 7'h58
`define SBD_IDX_IRQ_MASK 7'h59
// baud register fields
`define SBD_COARSE_HI 7
`define SBD_COARSE_LO 6
`define SBD_TXDIV_HI 5
`define SBD_TXDIV_LO 3
`define SBD_RXDIV_HI 2
`define SBD_RXDIV_LO 0
// coarse prescale factors
`define SBD_COARSE_F00 4'd1
`define SBD_COARSE_F01 4'd3
`define SBD_COARSE_F10 4'd4
`define SBD_COARSE_F11 4'd13
// fixed stage ahead of the extended prescaler
`define SBD_EXT_STAGE 5'd16
// status bit positions
`define SBD_ST_TXE 7
`define SBD_ST_TXDONE 6
`define SBD_ST_RXR 5
`define SBD_ST_IDLE 4
`define SBD_ST_OR 3
`define SBD_ST_NOISE 2
`define SBD_ST_FRAME 1
`define SBD_ST_PE 0
// control bit positions
`define SBD_C1_WORD9 4
// reset values
`define SBD_RST_STATUS 8'hc0
`define SBD_RST_ZERO 8'h00
// axi responses
`define SBD_RESP_OKAY 2'b00
`define SBD_RESP_SLVERR 2'b10
`endif

// >>> hdl/sbd_uart_regs.v
// Notes on behaviour
// - data write fills tx, read returns rx
// - tx shifter loads from tx holding register
// - finished rx character moves into rx holding
// - coarse code selects factor 1,3,4,13
// - tx rate = bus/(coarse*2^tx field)
// - rx rate = bus/(coarse*2^rx field)
// - nonzero ext rx value: /16 then /N
// - nonzero ext tx value: /16 then /N
// - extended prescalers cleared at reset
// - status access then data write clears tx flags
// - status access then data read clears rx flags
// - frame start, 8 or 9 data, stop
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "sbd_map.vh"
module sbd_uart_regs (
	// clock and reset
	input wire clk_i,
	input wire rstn_i,
	// axi4-lite write address and data
	input wire [8:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output reg s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output reg s_axi_wready_o,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp_o,
	output reg s_axi_bvalid_o,
	input wire s_axi_bready_i,
	// axi4-lite read
	input wire [8:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output reg s_axi_arready_o,
	output reg [31:0] s_axi_rdata_o,
	output reg [1:0] s_axi_rresp_o,
	output reg s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// shifter side
	// the serial shifters sit outside; only strobes, flags, bytes, the ready level and word9_o cross here
	input wire tx_shift_ready_i,
	input wire tx_frame_done_i,
	input wire rx_char_valid_i,
	input wire [7:0] rx_char_i,
	input wire rx_idle_i,
	input wire rx_noise_i,
	input wire rx_frame_err_i,
	input wire rx_parity_err_i,
	output reg tx_load_o,
	output reg [7:0] tx_shift_data_o,
	output reg word9_o,
	// rate clocks and interrupt
	// every output of this block comes straight from a flop
	output reg tx_rate_tick_o,
	output reg rx_rate_tick_o,
	output reg irq_o
);
	// register file
	// the data address fronts two separate registers: writes land in tx_holding_reg,
	// reads come from rx_holding_reg, so software never reads back what it sent
	reg [7:0] status; // flag bits
	reg [7:0] tx_holding_reg; // written by software
	reg [7:0] rx_holding_reg; // filled by the input shifter
	reg [7:0] baud_sel; // coarse and divisor fields
	reg [7:0] ctrl1; // control one
	reg [7:0] ctrl2; // control two
	reg [7:0] ext_rx_prescale_value; // extended receive divisor
	reg [7:0] ext_tx_prescale_value; // extended transmit divisor
	reg [7:0] irq_stat; // sticky event bits
	reg [7:0] irq_mask; // interrupt enables
	reg tx_armed; // status seen since last data write
	reg rx_armed; // status seen since last data read
	reg tx_pending; // holding register holds an unsent byte
	// bus bookkeeping
	// address and data may arrive in either order; each is parked until both are here
	// the write then commits in the same cycle that raises bvalid
	// only byte lane 0 carries register data; the other lanes are ignored
	reg aw_held;
	reg w_held;
	reg [6:0] aw_idx;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire [6:0] ar_idx = s_axi_araddr_i[8:2];
	wire wr_go = aw_held && w_held && !s_axi_bvalid_o;
	wire rd_go = s_axi_arvalid_i && s_axi_arready_o;
	wire wr_lane0 = wr_go && w_strb[0];
	wire wr_data = wr_lane0 && (aw_idx == `SBD_IDX_DATA);
	wire rd_data = rd_go && (ar_idx == `SBD_IDX_DATA);
	wire rd_status = rd_go && (ar_idx == `SBD_IDX_STATUS);
	// coarse factor decode
	// the coarse stage picks one of four fixed factors shared by both directions
	// code 11 gives the odd factor 13, so rates need not be powers of two
	reg [3:0] coarse_prescale_factor;
	always @* begin
		case (baud_sel[`SBD_COARSE_HI:`SBD_COARSE_LO])
			2'b00: coarse_prescale_factor = `SBD_COARSE_F00;
			2'b01: coarse_prescale_factor = `SBD_COARSE_F01;
			2'b10: coarse_prescale_factor = `SBD_COARSE_F10;
			default: coarse_prescale_factor = `SBD_COARSE_F11;
		endcase
	end
	// full period in bus clocks; ext stage replaces the binary divisor
	// both paths end in one count: coarse times either 2^field or 16 times the
	// extended value; the widest is 13 * 16 * 255 = 53040 clocks, so 16 bits suffice
	// a nonzero extended value overrides the binary field; the field is kept, so
	// clearing the extended value brings the earlier rate back
	wire [2:0] tx_divisor_sel = baud_sel[`SBD_TXDIV_HI:`SBD_TXDIV_LO];
	wire [2:0] rx_divisor_sel = baud_sel[`SBD_RXDIV_HI:`SBD_RXDIV_LO];
	wire [11:0] tx_divide_factor = 12'd1 << tx_divisor_sel;
	wire [11:0] rx_divide_factor = 12'd1 << rx_divisor_sel;
	wire [11:0] ext_tx_div = {4'h0, ext_tx_prescale_value} * {7'h00, `SBD_EXT_STAGE};
	wire [11:0] ext_rx_div = {4'h0, ext_rx_prescale_value} * {7'h00, `SBD_EXT_STAGE};
	wire [11:0] tx_mid = (ext_tx_prescale_value != 8'h00) ? ext_tx_div : tx_divide_factor;
	wire [11:0] rx_mid = (ext_rx_prescale_value != 8'h00) ? ext_rx_div : rx_divide_factor;
	wire [15:0] tx_period = tx_mid * {12'h000, coarse_prescale_factor};
	wire [15:0] rx_period = rx_mid * {12'h000, coarse_prescale_factor};
	reg [15:0] tx_cnt;
	reg [15:0] rx_cnt;
	reg [15:0] tx_limit; // latched only at period end
	reg [15:0] rx_limit;
	// rate counters: limits reload at wrap so a rewrite never cuts a period short
	// a tick is one clock wide and marks the start of each rate period
	// a setting written mid-period takes effect after the running period ends,
	// so every period runs in full at one of the two settings and no tick is doubled
	// after reset the limit is one, so the first tick comes on the first clock
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_cnt <= 16'h0000;
			rx_cnt <= 16'h0000;
			tx_limit <= 16'h0001;
			rx_limit <= 16'h0001;
			tx_rate_tick_o <= 1'b0;
			rx_rate_tick_o <= 1'b0;
		end else begin
			if (tx_cnt >= tx_limit - 16'h0001) begin
				tx_cnt <= 16'h0000;
				tx_limit <= tx_period;
				tx_rate_tick_o <= 1'b1;
			end else begin
				tx_cnt <= tx_cnt + 16'h0001;
				tx_rate_tick_o <= 1'b0;
			end
			if (rx_cnt >= rx_limit - 16'h0001) begin
				rx_cnt <= 16'h0000;
				rx_limit <= rx_period;
				rx_rate_tick_o <= 1'b1;
			end else begin
				rx_cnt <= rx_cnt + 16'h0001;
				rx_rate_tick_o <= 1'b0;
			end
		end
	end
	// write channel capture, either order
	// awready and wready drop once their item is parked and rise again only when
	// the response is taken, so at most one write is ever in flight
	// status, the hole and unmapped indices answer with an error and change nothing
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= 7'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `SBD_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				aw_idx <= s_axi_awaddr_i[8:2];
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				// writable map; status, hole and unmapped give an error
				if (aw_idx == `SBD_IDX_DATA || aw_idx == `SBD_IDX_BAUD ||
					aw_idx == `SBD_IDX_CTRL1 || aw_idx == `SBD_IDX_CTRL2 ||
					aw_idx == `SBD_IDX_EXT_RX || aw_idx == `SBD_IDX_EXT_TX ||
					aw_idx == `SBD_IDX_IRQ_STAT || aw_idx == `SBD_IDX_IRQ_MASK) begin
					s_axi_bresp_o <= `SBD_RESP_OKAY;
				end else begin
					s_axi_bresp_o <= `SBD_RESP_SLVERR;
				end
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end
	// register writes
	// registers change in the same cycle that the response is raised
	// status and irq_stat are kept by the flag process below
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_holding_reg <= `SBD_RST_ZERO;
			baud_sel <= `SBD_RST_ZERO;
			ctrl1 <= `SBD_RST_ZERO;
			ctrl2 <= `SBD_RST_ZERO;
			ext_rx_prescale_value <= `SBD_RST_ZERO;
			ext_tx_prescale_value <= `SBD_RST_ZERO;
			irq_mask <= `SBD_RST_ZERO;
		end else if (wr_lane0) begin
			if (aw_idx == `SBD_IDX_DATA) begin
				tx_holding_reg <= w_data[7:0];
			end else if (aw_idx == `SBD_IDX_BAUD) begin
				baud_sel <= w_data[7:0];
			end else if (aw_idx == `SBD_IDX_CTRL1) begin
				ctrl1 <= w_data[7:0];
			end else if (aw_idx == `SBD_IDX_CTRL2) begin
				ctrl2 <= w_data[7:0];
			end else if (aw_idx == `SBD_IDX_EXT_RX) begin
				ext_rx_prescale_value <= w_data[7:0];
			end else if (aw_idx == `SBD_IDX_EXT_TX) begin
				ext_tx_prescale_value <= w_data[7:0];
			end else if (aw_idx == `SBD_IDX_IRQ_MASK) begin
				irq_mask <= w_data[7:0];
			end
		end
	end
	// event pulses, laid out like status
	// each bit is a one-cycle set request for the matching status flag
	// overrun is judged against the flag as it stands, so a character that arrives
	// before software has read the previous one is flagged and dropped
	wire [7:0] ev_set;
	assign ev_set[`SBD_ST_TXE] = tx_load_o;
	assign ev_set[`SBD_ST_TXDONE] = tx_frame_done_i;
	assign ev_set[`SBD_ST_RXR] = rx_char_valid_i;
	assign ev_set[`SBD_ST_IDLE] = rx_idle_i;
	assign ev_set[`SBD_ST_OR] = rx_char_valid_i && status[`SBD_ST_RXR];
	assign ev_set[`SBD_ST_NOISE] = rx_char_valid_i && rx_noise_i;
	assign ev_set[`SBD_ST_FRAME] = rx_char_valid_i && rx_frame_err_i && !status[`SBD_ST_RXR];
	assign ev_set[`SBD_ST_PE] = rx_char_valid_i && rx_parity_err_i;
	wire tx_clr = wr_data && tx_armed;
	wire rx_clr = rd_data && rx_armed;
	// tx flags are bits 7:6; every other flag belongs to the receiver
	wire [7:0] clr_mask = {tx_clr, tx_clr, rx_clr, rx_clr, rx_clr, rx_clr, rx_clr, rx_clr};
	// flags, holding registers and shifter handshake; set wins over clear
	// a status read arms the clear sequence; the next data write clears the
	// transmit flags and the next data read clears the receive flags
	// a hardware set in the very cycle of a clear wins, so no event is lost
	// irq_o lags the sticky bit by one clock because it is registered
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status <= `SBD_RST_STATUS;
			rx_holding_reg <= `SBD_RST_ZERO;
			irq_stat <= `SBD_RST_ZERO;
			tx_armed <= 1'b0;
			rx_armed <= 1'b0;
			tx_pending <= 1'b0;
			tx_load_o <= 1'b0;
			tx_shift_data_o <= `SBD_RST_ZERO;
			word9_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			status <= (status & ~clr_mask) | ev_set;
			// overrun keeps the old character
			if (rx_char_valid_i && !status[`SBD_ST_RXR]) begin
				rx_holding_reg <= rx_char_i;
			end
			if (rd_status) begin
				tx_armed <= 1'b1;
				rx_armed <= 1'b1;
			end else begin
				if (wr_data) tx_armed <= 1'b0;
				if (rd_data) rx_armed <= 1'b0;
			end
			// a byte only leaves once software has refilled the holding register
			// tx_load_o is kept low for a cycle after each load, so the shifter
			// sees a single pulse even when its ready input lags by a clock
			tx_load_o <= 1'b0;
			if (wr_data) begin
				tx_pending <= 1'b1;
			end else if (tx_pending && tx_shift_ready_i && !tx_load_o) begin
				tx_pending <= 1'b0;
				tx_load_o <= 1'b1;
				tx_shift_data_o <= tx_holding_reg;
			end
			// word length passes through a flop; software must not change it mid-frame
			word9_o <= ctrl1[`SBD_C1_WORD9];
			// write one to clear; an event in the same cycle keeps its bit
			if (wr_lane0 && aw_idx == `SBD_IDX_IRQ_STAT) begin
				irq_stat <= (irq_stat & ~w_data[7:0]) | ev_set;
			end else begin
				irq_stat <= irq_stat | ev_set;
			end
			irq_o <= |(irq_stat & irq_mask);
		end
	end
	// read channel: one-cycle answer
	// arready drops while the answer waits, so one read is in flight at a time
	// unmapped indices read zero with an error; the hole reads zero with okay
	// a data read is what the receive clear sequence counts as its second step
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= `SBD_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= `SBD_RESP_OKAY;
			if (ar_idx == `SBD_IDX_STATUS) begin
				s_axi_rdata_o <= {24'h000000, status};
			end else if (ar_idx == `SBD_IDX_DATA) begin
				s_axi_rdata_o <= {24'h000000, rx_holding_reg};
			end else if (ar_idx == `SBD_IDX_BAUD) begin
				s_axi_rdata_o <= {24'h000000, baud_sel};
			end else if (ar_idx == `SBD_IDX_CTRL1) begin
				s_axi_rdata_o <= {24'h000000, ctrl1};
			end else if (ar_idx == `SBD_IDX_CTRL2) begin
				s_axi_rdata_o <= {24'h000000, ctrl2};
			end else if (ar_idx == `SBD_IDX_EXT_RX) begin
				s_axi_rdata_o <= {24'h000000, ext_rx_prescale_value};
			end else if (ar_idx == `SBD_IDX_HOLE) begin
				s_axi_rdata_o <= 32'h00000000;
			end else if (ar_idx == `SBD_IDX_EXT_TX) begin
				s_axi_rdata_o <= {24'h000000, ext_tx_prescale_value};
			end else if (ar_idx == `SBD_IDX_IRQ_STAT) begin
				s_axi_rdata_o <= {24'h000000, irq_stat};
			end else if (ar_idx == `SBD_IDX_IRQ_MASK) begin
				s_axi_rdata_o <= {24'h000000, irq_mask};
			end else begin
				s_axi_rdata_o <= 32'h00000000;
				s_axi_rresp_o <= `SBD_RESP_SLVERR;
			end
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end
endmodule

// >>> bench/sbd_regs_assertions.sv
`timescale 1ns/10ps
module sbd_regs_check (
	// clock and reset
	input wire clk_i,
	input wire rstn_i,
	// axi write side
	input wire [8:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	input wire s_axi_awready_o,
	input wire s_axi_wvalid_i,
	input wire s_axi_wready_o,
	input wire [1:0] s_axi_bresp_o,
	input wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	// axi read side
	input wire [8:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire [31:0] s_axi_rdata_o,
	input wire s_axi_rvalid_o,
	input wire s_axi_rready_i
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// address and data taken at the same edge
	sequence wr_take;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	// read address taken
	sequence rd_take;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	b_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid_o) else $error("no write response");
	b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("write response dropped");
	aw_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while response pending");
	r_answer_a: assert property (rd_take |=> s_axi_rvalid_o) else $error("no read answer");
	r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer unstable");
	ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while answer pending");
	r_upper_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	hole_read_a: assert property (rd_take ##0 s_axi_araddr_i == 9'h158
		|=> s_axi_rdata_o == 32'h0) else $error("unused address reads nonzero");
	hole_write_a: assert property (wr_take ##0 s_axi_awaddr_i == 9'h158
		|-> ##2 s_axi_bresp_o == 2'b10) else $error("unused address write accepted");
endmodule
bind sbd_uart_regs sbd_regs_check chk (.clk_i(clk_i), .rstn_i(rstn_i),
	.s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i));

// >>> bench/sbd_far_model.sv
`timescale 1ns/10ps
module sbd_far_model (
	// clock and reset
	input wire clk_i,
	input wire rstn_i,
	// transmit shifter
	input wire load_i,
	input wire [7:0] data_i,
	output reg ready_o,
	output reg done_o,
	// receive shifter
	output reg cv_o,
	output reg [7:0] ch_o,
	output reg nz_o
);
	reg [7:0] last_tx; // byte the shifter last took
	reg [3:0] busy; // cycles left in the frame
	initial begin
		cv_o = 1'b0;
		ch_o = 8'h00;
		nz_o = 1'b0;
	end
	// shifter stays busy ten cycles a frame, so loads must wait for it
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy <= 4'h0;
			ready_o <= 1'b1;
			done_o <= 1'b0;
			last_tx <= 8'h00;
		end else begin
			done_o <= (busy == 4'h1);
			ready_o <= (busy <= 4'h1) && !load_i;
			if (load_i) begin
				last_tx <= data_i;
				busy <= 4'ha;
			end else if (busy != 4'h0) begin
				busy <= busy - 4'h1;
			end
		end
	end
	// one finished character; qualifiers are scrambled outside the strobe
	task push(input [7:0] d, input n);
		begin
			@(posedge clk_i);
			cv_o <= 1'b1;
			ch_o <= d;
			nz_o <= n;
			@(posedge clk_i);
			cv_o <= 1'b0;
			ch_o <= ~d;
			nz_o <= ~n;
		end
	endtask
endmodule

// >>> bench/uart_baud_and_data_regs_bench.sv
`timescale 1ns/10ps
module uart_baud_and_data_regs_bench;
	reg clk_i = 1'b0;
	reg rstn_i = 1'b0;
	reg [8:0] awaddr = 9'h0;
	reg [8:0] araddr = 9'h0;
	reg [31:0] wdata = 32'h0;
	reg awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	wire awready, wready, bvalid, arready, rvalid, rdy, done, cv, nz;
	wire ld, word9, txt, rxt, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] txd, ch;
	reg [31:0] got; // last read data
	reg [1:0] resp; // last response code
	reg fin;
	integer bad_count, cmp_count, n;
	always #10 clk_i = ~clk_i;
	sbd_uart_regs dut (.clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .tx_shift_ready_i(rdy), .tx_frame_done_i(done),
		.rx_char_valid_i(cv), .rx_char_i(ch), .rx_idle_i(1'b0), .rx_noise_i(nz),
		.rx_frame_err_i(nz), .rx_parity_err_i(1'b0), .tx_load_o(ld),
		.tx_shift_data_o(txd), .word9_o(word9), .tx_rate_tick_o(txt),
		.rx_rate_tick_o(rxt), .irq_o(irq));
	sbd_far_model far (.clk_i(clk_i), .rstn_i(rstn_i), .load_i(ld), .data_i(txd),
		.ready_o(rdy), .done_o(done), .cv_o(cv), .ch_o(ch), .nz_o(nz));
	// compare and count
	task check(input [31:0] seen, input [31:0] exp, input string what);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("wrong value %0s expected %h seen %h", what, exp, seen);
		end
	endtask
	// write: each channel released when taken, bready held until answer
	task wr(input [8:0] a, input [7:0] d);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		fin = 1'b0;
		while (!fin) begin
			@(posedge clk_i);
			if (awready) awv <= 1'b0;
			if (wready) wv <= 1'b0;
			if (bvalid) begin
				resp = bresp;
				fin = 1'b1;
			end
		end
		bready <= 1'b0;
	endtask
	// read: data taken at the edge where rvalid is seen
	task rd(input [8:0] a);
		@(posedge clk_i);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		fin = 1'b0;
		while (!fin) begin
			@(posedge clk_i);
			if (arready) arv <= 1'b0;
			if (rvalid) begin
				got = rdata;
				resp = rresp;
				fin = 1'b1;
			end
		end
		rready <= 1'b0;
	endtask
	// cycles between two rate ticks, after the running period has ended
	task period(input tx, input [31:0] exp);
		repeat (2) begin
			@(posedge clk_i);
			while (!(tx ? txt : rxt)) @(posedge clk_i);
		end
		n = 1;
		@(posedge clk_i);
		while (!(tx ? txt : rxt)) begin
			n = n + 1;
			@(posedge clk_i);
		end
		check(n, exp, tx ? "tx period" : "rx period");
	endtask
	task t_reset;
		rd(9'h140);
		check(got, 32'hc0, "status");
		rd(9'h148);
		check(got, 32'h0, "baud");
		rd(9'h154);
		check(got, 32'h0, "ext rx");
		rd(9'h15c);
		check(got, 32'h0, "ext tx");
	endtask
	// one address, two registers
	task t_data;
		wr(9'h144, 8'h5a);
		n = 0;
		while (far.last_tx !== 8'h5a && n < 50) begin
			n = n + 1;
			@(posedge clk_i);
		end
		check(far.last_tx, 8'h5a, "shifted byte");
		far.push(8'ha5, 1'b0);
		rd(9'h140);
		rd(9'h144);
		check(got, 32'ha5, "rx byte");
	endtask
	task t_flags;
		far.push(8'h3c, 1'b1);
		rd(9'h140);
		check({got[5], got[2], got[1]}, 3'b111, "rx flags set");
		rd(9'h144);
		check(got, 32'h3c, "rx byte");
		rd(9'h140);
		check({got[5], got[2], got[1]}, 3'b000, "rx flags clear");
		wr(9'h144, 8'h11);
		rd(9'h140);
		check(got[6], 1'b0, "tx complete clear");
		repeat (30) @(posedge clk_i);
		rd(9'h140);
		check(got[6], 1'b1, "tx complete set");
	endtask
	task t_rate(input [7:0] b, input [7:0] et, input [7:0] er, input [31:0] pt,
		input [31:0] pr);
		wr(9'h15c, et);
		wr(9'h154, er);
		wr(9'h148, b);
		period(1'b1, pt);
		period(1'b0, pr);
	endtask
	task t_decode;
		rd(9'h158);
		check(got, 32'h0, "hole read");
		wr(9'h158, 8'hff);
		check(resp, 2'b10, "hole write");
		rd(9'h1fc);
		check(resp, 2'b10, "unmapped read");
		wr(9'h14c, 8'h10);
		@(posedge clk_i);
		check(word9, 1'b1, "word9");
	endtask
	task t_irq;
		wr(9'h160, 8'hff);
		wr(9'h164, 8'h20);
		repeat (2) @(posedge clk_i);
		check(irq, 1'b0, "irq idle");
		far.push(8'h77, 1'b0);
		repeat (3) @(posedge clk_i);
		check(irq, 1'b1, "irq raised");
		wr(9'h164, 8'h00);
		repeat (2) @(posedge clk_i);
		check(irq, 1'b0, "irq masked");
		wr(9'h160, 8'h20);
		wr(9'h164, 8'h20);
		repeat (2) @(posedge clk_i);
		check(irq, 1'b0, "irq cleared");
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog sized well above the longest run
	initial begin
		#2000000;
		bad_count = bad_count + 1;
		close_out;
	end
	initial begin
		bad_count = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset;
		t_data;
		t_flags;
		t_rate(8'h0a, 8'h0, 8'h0, 2, 4);
		t_rate(8'h4a, 8'h0, 8'h0, 6, 12);
		t_rate(8'h8a, 8'h0, 8'h0, 8, 16);
		t_rate(8'hf8, 8'h0, 8'h0, 1664, 13);
		t_rate(8'h40, 8'h3, 8'h2, 144, 96);
		t_decode;
		t_irq;
		close_out;
	end
endmodule
